// [core/dhr_pkg.sv]
// Shared constants and carrier types of the D-channel HDLC receiver.
// Assumes one synchronous clock domain.
package dhr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 128;
  localparam logic [6:0] SEG_FULL = 7'h40; // Block of 64 bytes
  localparam logic [6:0] SEG_FIRST = 7'h01;

  ////////////////////////////////////////////////////////////////////////
  // Frame check sequence, bit-reversed x^16 + x^12 + x^5 + 1
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8; // Residue over data + FCS

  ////////////////////////////////////////////////////////////////////////
  // Fixed group address values
  localparam logic [7:0] GROUP_SAPI_VALUE = 8'h00; // SAPI 0, C/R = 0
  localparam logic [7:0] GROUP_SAPI_CR_BIT = 8'h02; // C/R = 1 gives 02
  localparam logic [7:0] GROUP_ENDPOINT_VALUE = 8'hff; // TEI 127

  ////////////////////////////////////////////////////////////////////////
  // Bit-level framing counts
  localparam logic [2:0] ONES_STUFF = 3'h5;
  localparam logic [2:0] ONES_FLAG = 3'h6;
  localparam logic [2:0] ONES_ABORT = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] ADDR_BYTES = 3'h2;
  localparam logic [2:0] MIN_FRAME_BYTES = 3'h4; // Address + FCS
  localparam logic [2:0] NBYTES_SAT = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic {DHR_HUNT, DHR_SYNC} dhr_link_e;

  // One entry between deframer and FIFO: a data byte or an end marker
  typedef struct packed {
    logic eom;
    logic bad;
    logic [7:0] data;
  } dhr_item_s;

endpackage

// [core/dhr_byte_ram.sv]
// Byte memory of the receive FIFO with registered read data.
// Assumes the owner keeps addresses in range and never reads and writes
// one word in the same cycle expecting the new value.
`timescale 1ns/1ns
module dhr_byte_ram #(
  parameter int DEPTH = dhr_pkg::FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("dhr_byte_ram depth must be a power of two");
  end

  ////////////////////////////////////////////////////////////////////////
  // Write port and registered read port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// [core/dhr_skid2.sv]
// Two-entry buffer carrying deframer items towards the receive FIFO.
// Assumes the consumer drops out_ready only while it is really full.
`timescale 1ns/1ns
module dhr_skid2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input dhr_pkg::dhr_item_s in_data,
  output logic out_valid,
  input wire logic out_ready,
  output dhr_pkg::dhr_item_s out_data
);
  typedef struct packed {
    dhr_pkg::dhr_item_s e0;
    dhr_pkg::dhr_item_s e1;
    logic [1:0] n;
  } dhr_skid_state_s;

  dhr_skid_state_s st_reg;
  dhr_skid_state_s st_next;
  logic push;
  logic pop;

  assign in_ready = (st_reg.n != 2'h2);
  assign out_valid = (st_reg.n != 2'h0);
  assign out_data = st_reg.e0;

  ////////////////////////////////////////////////////////////////////////
  // Pop from the head, then append behind what is left
  always_comb begin
    st_next = st_reg;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (pop) begin
      st_next.e0 = st_reg.e1;
      st_next.n = st_reg.n - 2'h1;
    end
    if (push) begin
      if (st_next.n == 2'h0) begin
        st_next.e0 = in_data;
      end else begin
        st_next.e1 = in_data;
      end
      st_next.n = st_next.n + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_skid_bound: assert property (@(posedge clk) disable iff (rst)
    st_reg.n != 2'h3) else $error("skid buffer count out of range");
endmodule

// [core/dhr_receiver.sv]
// D-channel HDLC receiver: deframing, FCS check, address filter,
// 128-byte receive FIFO with block and end-of-message signalling.
// Assumes RX_BIT_STROBE marks each layer 1 D-channel bit, one per pulse,
// and that all inputs are synchronous to MCLK.
//
// Contract
// - Detect and drop opening and closing flags and stuffed zeros.
// - Check the 16-bit FCS with x^16 + x^12 + x^5 + 1.
// - Two programmable SAPI and two TEI values plus fixed group values.
// - Group SAPI is 02 with C/R one, 00 with C/R zero.
// - Group TEI value is FF, TEI 127.
// - Accept only the listed SAPI and TEI pairings.
// - Accepted frames go to the FIFO without flags, FCS or stuffing.
// - Mask bits drop programmed-value bits; group compares never masked.
// - Receive data buffered in a 128-byte FIFO, moved by interrupts.
// - Block-ready after 64 bytes of an unfinished frame; host reads 64.
// - End-of-message for a last segment, with its length reported.
// - Final segment of exactly 64 gives end only, count field zero.
// - Stored data run from after opening flag up to the FCS.
// - LAPD frames carry two address and two control octets.
// - Late service with lost bytes raises overflow interrupt and status.
`timescale 1ns/1ns
module dhr_receiver #(
  parameter int DEPTH = dhr_pkg::FIFO_DEPTH
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic RX_BIT,
  input wire logic RX_BIT_STROBE,
  input wire logic [7:0] SAPI_MATCH_FIRST,
  input wire logic [7:0] SAPI_MATCH_SECOND,
  input wire logic [7:0] ENDPOINT_MATCH_FIRST,
  input wire logic [7:0] ENDPOINT_MATCH_SECOND,
  input wire logic [7:0] SAPI_BIT_MASK,
  input wire logic [7:0] ENDPOINT_BIT_MASK,
  input wire logic RX_ACKNOWLEDGE_CMD,
  input wire logic RX_FIFO_READ,
  output logic [7:0] RX_FIFO_PORT,
  output logic [$clog2(DEPTH):0] RX_FIFO_LEVEL,
  output logic RX_BLOCK_READY_IRQ,
  output logic RX_MESSAGE_END_IRQ,
  output logic [5:0] RX_COUNT_FIELD,
  output logic RX_OVERFLOW_IRQ,
  output logic RX_OVERFLOW_STATUS,
  output logic RX_CRC_ERROR
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] LEVEL_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_W = (AW+1)'(1);

  if ((DEPTH != (1 << AW)) || (DEPTH < 128)) begin : g_bad_depth
    $error("dhr_receiver depth must be a power of two, at least 128");
  end

  ////////////////////////////////////////////////////////////////////////
  // State of the whole receiver
  typedef struct packed {
    dhr_pkg::dhr_link_e link;
    logic [2:0] ones;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [2:0] nbytes;
    logic [7:0] addr1;
    logic [7:0] hold0;
    logic [7:0] hold1;
    logic accept;
    logic [15:0] crc;
    logic [15:0] crc_byte;
    logic emit;
    dhr_pkg::dhr_item_s item;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] level;
    logic [6:0] seg;
    logic rmr;
    logic rme;
    logic [5:0] cnt;
    logic ovf_irq;
    logic ovf_stat;
    logic crc_err;
    logic end_wait;
  } dhr_rx_state_s;

  dhr_rx_state_s st_reg;
  dhr_rx_state_s st_next;

  logic push;
  logic byte_done;
  logic [7:0] new_byte;
  logic rx_acknowledge_cmd;
  logic take;
  logic wr_en;
  logic rd_en;
  logic rmr_set;
  logic rme_set;
  logic ovf_set;
  logic stat_clr;
  logic sk_in_ready;
  logic sk_out_valid;
  logic sk_out_ready;
  dhr_pkg::dhr_item_s sk_out;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? dhr_pkg::CRC_POLY_REV : 16'h0000);
  endfunction

  // Equal on every bit whose mask bit is zero
  function automatic logic masked_eq(logic [7:0] a, logic [7:0] b,
                                     logic [7:0] m);
    masked_eq = (((a ^ b) & ~m) == 8'h00);
  endfunction

  // Group SAPI in either C/R state, never masked
  function automatic logic group_sapi(logic [7:0] a);
    group_sapi = ((a & ~dhr_pkg::GROUP_SAPI_CR_BIT) ==
                  dhr_pkg::GROUP_SAPI_VALUE);
  endfunction

  // Address pair filter
  function automatic logic addr_ok(logic [7:0] a1, logic [7:0] a2);
    logic s1;
    logic s2;
    logic t1;
    logic t2;
    logic tg;
    s1 = masked_eq(a1, SAPI_MATCH_FIRST, SAPI_BIT_MASK);
    s2 = masked_eq(a1, SAPI_MATCH_SECOND, SAPI_BIT_MASK);
    t1 = masked_eq(a2, ENDPOINT_MATCH_FIRST, ENDPOINT_BIT_MASK);
    t2 = masked_eq(a2, ENDPOINT_MATCH_SECOND, ENDPOINT_BIT_MASK);
    tg = (a2 == dhr_pkg::GROUP_ENDPOINT_VALUE);
    addr_ok = (s1 && (t1 || tg)) || (s2 && (t2 || tg)) ||
              (group_sapi(a1) && (t1 || t2 || tg));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.emit = 1'b0;
    push = 1'b0;
    byte_done = 1'b0;
    new_byte = {RX_BIT, st_reg.shreg[7:1]};
    rx_acknowledge_cmd = RX_ACKNOWLEDGE_CMD;
    stat_clr = 1'b0;

    // Flag, abort and stuffed-zero detection on each line bit
    if (RX_BIT_STROBE) begin
      if (RX_BIT) begin
        if (st_reg.ones == dhr_pkg::ONES_FLAG) begin
          // Seventh one aborts; close any frame already in the FIFO
          if (st_reg.link == dhr_pkg::DHR_SYNC && st_reg.accept &&
              st_reg.nbytes > dhr_pkg::ADDR_BYTES) begin
            st_next.emit = 1'b1;
            st_next.item = '{eom: 1'b1, bad: 1'b1, data: 8'h00};
          end
          st_next.link = dhr_pkg::DHR_HUNT;
          st_next.ones = dhr_pkg::ONES_ABORT;
        end else begin
          if (st_reg.ones != dhr_pkg::ONES_ABORT) begin
            st_next.ones = st_reg.ones + 3'h1;
          end
          push = 1'b1;
        end
      end else begin
        st_next.ones = 3'h0;
        if (st_reg.ones == dhr_pkg::ONES_FLAG) begin
          // Closing flag ends the frame; FCS bytes stay behind in hold
          if (st_reg.link == dhr_pkg::DHR_SYNC && st_reg.accept &&
              st_reg.nbytes > dhr_pkg::ADDR_BYTES) begin
            st_next.emit = 1'b1;
            st_next.item.eom = 1'b1;
            st_next.item.data = 8'h00;
            st_next.item.bad = (st_reg.crc_byte != dhr_pkg::CRC_GOOD) ||
              (st_reg.nbytes < dhr_pkg::MIN_FRAME_BYTES) ||
              (st_reg.bitcnt != dhr_pkg::BIT_LAST);
          end
          // Every flag opens a fresh frame
          st_next.link = dhr_pkg::DHR_SYNC;
          st_next.bitcnt = 3'h0;
          st_next.nbytes = 3'h0;
          st_next.accept = 1'b0;
          st_next.crc = dhr_pkg::CRC_INIT;
          st_next.crc_byte = dhr_pkg::CRC_INIT;
        end else if (st_reg.ones != dhr_pkg::ONES_STUFF) begin
          push = 1'b1; // A zero after five ones is stuffing, dropped
        end
      end
    end

    // Data bits, LSB first, into bytes and the FCS register
    if (push && st_reg.link == dhr_pkg::DHR_SYNC) begin
      st_next.crc = crc_step(st_reg.crc, RX_BIT);
      st_next.shreg = new_byte;
      st_next.bitcnt = st_reg.bitcnt + 3'h1;
      byte_done = (st_reg.bitcnt == dhr_pkg::BIT_LAST);
    end
    if (byte_done) begin
      // Snapshot at byte edges so flag bits never reach the check
      st_next.crc_byte = st_next.crc;
      if (st_reg.nbytes != dhr_pkg::NBYTES_SAT) begin
        st_next.nbytes = st_reg.nbytes + 3'h1;
      end
      // Two-byte delay keeps the trailing FCS out of the FIFO
      st_next.hold0 = st_reg.hold1;
      st_next.hold1 = new_byte;
      if (st_reg.nbytes == 3'h0) begin
        st_next.addr1 = new_byte;
      end
      if (st_reg.nbytes == 3'h1) begin
        st_next.accept = addr_ok(st_reg.addr1, new_byte);
        stat_clr = st_next.accept;
      end
      if (st_reg.nbytes >= dhr_pkg::ADDR_BYTES && st_reg.accept) begin
        st_next.emit = 1'b1;
        st_next.item = '{eom: 1'b0, bad: 1'b0, data: st_reg.hold0};
      end
    end

    // FIFO write side drains the two-entry buffer
    sk_out_ready = sk_out.eom || (st_reg.level != LEVEL_FULL);
    take = sk_out_valid && sk_out_ready;
    wr_en = take && !sk_out.eom;
    rme_set = take && sk_out.eom;
    rmr_set = wr_en && (st_reg.seg == dhr_pkg::SEG_FULL);
    rd_en = RX_FIFO_READ && (st_reg.level != '0);
    ovf_set = st_reg.emit && !st_reg.item.eom && !sk_in_ready;

    // End marker meeting a full buffer waits, so segments restart
    if (st_reg.emit && st_reg.item.eom && !sk_in_ready) begin
      st_next.end_wait = 1'b1;
    end else if (sk_in_ready || st_next.emit) begin
      st_next.end_wait = 1'b0;
    end

    // Pointers and level
    if (wr_en) begin
      st_next.wptr = st_reg.wptr + ONE_W;
    end
    if (rd_en) begin
      st_next.rptr = st_reg.rptr + ONE_W;
    end
    st_next.level = st_next.wptr - st_next.rptr;

    // Segment counting: the 65th byte proves the frame goes on
    if (wr_en) begin
      st_next.seg = rmr_set ? dhr_pkg::SEG_FIRST : st_reg.seg + 7'h01;
    end
    if (rme_set) begin
      st_next.seg = 7'h00;
      st_next.cnt = st_reg.seg[5:0];
      st_next.crc_err = sk_out.bad;
    end

    // Sticky flags; a new event wins over the acknowledge
    st_next.rmr = (st_reg.rmr && !rx_acknowledge_cmd) || rmr_set;
    st_next.rme = (st_reg.rme && !rx_acknowledge_cmd) || rme_set;
    st_next.ovf_irq = (st_reg.ovf_irq && !rx_acknowledge_cmd) || ovf_set;
    st_next.ovf_stat = (st_reg.ovf_stat && !stat_clr) || ovf_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_reg <= '0;
      st_reg.crc <= dhr_pkg::CRC_INIT;
      st_reg.crc_byte <= dhr_pkg::CRC_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer and memory
  dhr_skid2 u_skid (
    .clk(MCLK),
    .rst(SRST),
    .in_valid(st_reg.emit || st_reg.end_wait),
    .in_ready(sk_in_ready),
    .in_data(st_reg.item),
    .out_valid(sk_out_valid),
    .out_ready(sk_out_ready),
    .out_data(sk_out)
  );

  dhr_byte_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
    .clk(MCLK),
    .rst(SRST),
    .wr_en(wr_en),
    .wr_addr(st_reg.wptr[AW-1:0]),
    .wr_data(sk_out.data),
    .rd_en(rd_en),
    .rd_addr(st_reg.rptr[AW-1:0]),
    .rd_data(RX_FIFO_PORT)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from state flops
  assign RX_FIFO_LEVEL = st_reg.level;
  assign RX_BLOCK_READY_IRQ = st_reg.rmr;
  assign RX_MESSAGE_END_IRQ = st_reg.rme;
  assign RX_COUNT_FIELD = st_reg.cnt;
  assign RX_OVERFLOW_IRQ = st_reg.ovf_irq;
  assign RX_OVERFLOW_STATUS = st_reg.ovf_stat;
  assign RX_CRC_ERROR = st_reg.crc_err;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  sequence s_end_taken;
    rme_set ##1 st_reg.rme;
  endsequence

  sequence s_block_taken;
    rmr_set ##1 (st_reg.rmr && st_reg.seg == dhr_pkg::SEG_FIRST);
  endsequence

  a_stuff_drop: assert property (
    (RX_BIT_STROBE && !RX_BIT && st_reg.ones == dhr_pkg::ONES_STUFF &&
     st_reg.link == dhr_pkg::DHR_SYNC)
    |=> (st_reg.bitcnt == $past(st_reg.bitcnt)))
    else $error("stuffed zero was taken as data");

  a_fcs_good: assert property (
    (st_next.emit && st_next.item.eom && !st_next.item.bad)
    |-> (st_reg.crc_byte == dhr_pkg::CRC_GOOD))
    else $error("frame passed with a bad FCS");

  a_group_accept: assert property (
    (byte_done && st_reg.nbytes == 3'h1 && group_sapi(st_reg.addr1) &&
     new_byte == dhr_pkg::GROUP_ENDPOINT_VALUE) |=> st_reg.accept)
    else $error("group address pair refused");

  a_mask_all: assert property (
    (byte_done && st_reg.nbytes == 3'h1 && SAPI_BIT_MASK == 8'hff &&
     ENDPOINT_BIT_MASK == 8'hff) |=> st_reg.accept)
    else $error("fully masked address refused");

  a_fifo_bound: assert property (
    (st_reg.level <= LEVEL_FULL) &&
    (st_reg.level == st_reg.wptr - st_reg.rptr))
    else $error("FIFO level inconsistent");

  a_block_ready: assert property (
    rmr_set |-> s_block_taken)
    else $error("block-ready not raised on 65th byte");

  a_end_count: assert property (
    rme_set |-> s_end_taken ##0
    (RX_COUNT_FIELD == $past(st_reg.seg[5:0])))
    else $error("end count wrong");

  a_exact_block: assert property (
    (rme_set && st_reg.seg == dhr_pkg::SEG_FULL && !st_reg.rmr)
    |=> (RX_COUNT_FIELD == 6'h00 && !st_reg.rmr))
    else $error("64-byte last segment misreported");

  a_rx_acknowledge_cmd_clear: assert property (
    (rx_acknowledge_cmd && !rme_set && !rmr_set) |=> (!st_reg.rme && !st_reg.rmr))
    else $error("acknowledge did not clear interrupts");

  a_overflow_flag: assert property (
    ovf_set |=> (RX_OVERFLOW_IRQ && RX_OVERFLOW_STATUS))
    else $error("overflow not flagged");

  a_read_step: assert property (
    rd_en |=> (st_reg.rptr == $past(st_reg.rptr) + ONE_W))
    else $error("read pointer did not advance by one");
endmodule

// [tb/dhr_l1_model.sv]
// Layer 1 D-channel source that sends HDLC frames as strobed line bits.
// Assumes the receiver samples the line on the clock when strobe is high.
`timescale 1ns/1ns
module dhr_l1_model (
  input wire logic clk,
  output logic line_bit,
  output logic bit_strobe
);
  int ones;

  // Idle line at time zero
  initial begin
    line_bit = 1'b1;
    bit_strobe = 1'b0;
    ones = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One line bit; strobes four cycles apart, line inverted in between
  task automatic put_bit(input logic b);
    @(posedge clk);
    line_bit <= b;
    bit_strobe <= 1'b1;
    @(posedge clk);
    bit_strobe <= 1'b0;
    line_bit <= ~b;
    repeat (2) @(posedge clk);
  endtask

  // Data bit, a zero inserted after five ones
  task automatic put_data(input logic b);
    put_bit(b);
    ones = b ? ones + 1 : 0;
    if (ones == 5) begin
      put_bit(1'b0);
      ones = 0;
    end
  endtask

  // Flag pattern, never stuffed
  task automatic put_flag();
    for (int i = 0; i < 8; i++) begin
      put_bit(i != 0 && i != 7);
    end
    ones = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Frame: two flags, bytes LSB first, FCS low byte first, closing flag
  task automatic send_frame(input logic [7:0] q [$], input logic bad);
    logic [15:0] crc;
    logic [15:0] fcs;
    crc = 16'hffff;
    put_flag();
    put_flag();
    foreach (q[k]) begin
      for (int i = 0; i < 8; i++) begin
        put_data(q[k][i]);
        crc = (crc[0] ^ q[k][i]) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
      end
    end
    fcs = ~crc ^ {15'h0000, bad};
    for (int i = 0; i < 16; i++) begin
      put_data(fcs[i]);
    end
    put_flag();
  endtask

  // Frame cut short: one flag, data bytes, then seven ones unstuffed
  task automatic send_abort(input logic [7:0] q [$]);
    put_flag();
    foreach (q[k]) begin
      for (int i = 0; i < 8; i++) begin
        put_data(q[k][i]);
      end
    end
    for (int i = 0; i < 7; i++) begin
      put_bit(1'b1);
    end
    ones = 0;
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the D-channel HDLC receiver.
// Assumes the layer 1 source model and a host modelled by tasks here.
`timescale 1ns/1ns
module testbench;
  logic mclk, srst, ack, rd, rx_bit, rx_strobe;
  logic [7:0] sapi_match_first, sapi_match_second, endpoint_match_first, endpoint_match_second, smask, tmask, port, level, d;
  logic blk, eom, ovf, ovs, crce;
  logic [5:0] cnt;
  int n_fail;
  int checks;
  logic [7:0] q [$];
  logic [16:0] tab [11] = '{17'h11823, 17'h118ff, 17'h14045, 17'h140ff,
    17'h10023, 17'h10245, 17'h100ff, 17'h01845, 17'h04023, 17'h00277,
    17'h02623};

  dhr_l1_model dhr_l1_model_i (.clk(mclk), .line_bit(rx_bit),
    .bit_strobe(rx_strobe));

  dhr_receiver #(.DEPTH(128)) dhr_receiver_i (.MCLK(mclk), .SRST(srst),
    .RX_BIT(rx_bit), .RX_BIT_STROBE(rx_strobe), .SAPI_MATCH_FIRST(sapi_match_first),
    .SAPI_MATCH_SECOND(sapi_match_second), .ENDPOINT_MATCH_FIRST(endpoint_match_first),
    .ENDPOINT_MATCH_SECOND(endpoint_match_second), .SAPI_BIT_MASK(smask),
    .ENDPOINT_BIT_MASK(tmask), .RX_ACKNOWLEDGE_CMD(ack),
    .RX_FIFO_READ(rd), .RX_FIFO_PORT(port), .RX_FIFO_LEVEL(level),
    .RX_BLOCK_READY_IRQ(blk), .RX_MESSAGE_END_IRQ(eom),
    .RX_COUNT_FIELD(cnt), .RX_OVERFLOW_IRQ(ovf),
    .RX_OVERFLOW_STATUS(ovs), .RX_CRC_ERROR(crce));

  // Clock of 40 ns
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Frame contents: two address octets then counted filler bytes
  task automatic mk(input logic [7:0] a1, input logic [7:0] a2, int n);
    q = {};
    q.push_back(a1);
    q.push_back(a2);
    for (int i = 2; i < n; i++) q.push_back(8'(i * 29 + 3));
  endtask

  // Host pop: data shows just after the edge that takes the read
  task automatic rd_byte();
    @(posedge mclk) rd <= 1'b1;
    @(posedge mclk) rd <= 1'b0;
    #1 d = port;
  endtask

  task automatic wait_end();
    int i;
    i = 0;
    while (eom !== 1'b1 && i < 400) begin
      @(posedge mclk);
      i++;
    end
    #1;
  endtask

  // Send, then expect end, its count, FCS verdict and level
  task automatic frame_ok(input int n, input logic bad);
    dhr_l1_model_i.send_frame(q, bad);
    wait_end();
    chk(eom, 1'b1);
    chk(cnt, 6'(n));
    chk(crce, bad);
    chk(level, 8'(n));
  endtask

  // Send a frame the filter must drop; nothing may show
  task automatic frame_drop();
    dhr_l1_model_i.send_frame(q, 1'b0);
    repeat (20) @(posedge mclk);
    #1 chk(eom, 1'b0);
    chk(level, 8'h00);
  endtask

  // Read n bytes against the frame, then acknowledge
  task automatic drain(input int n);
    for (int i = 0; i < n; i++) begin
      rd_byte();
      chk(d, q[i]);
    end
    while (level !== 8'h00) rd_byte();
    @(posedge mclk) ack <= 1'b1;
    @(posedge mclk) ack <= 1'b0;
    #1 chk({blk, eom, ovf}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_fail = 0;
    checks = 0;
    srst = 1'b1;
    ack = 1'b0;
    rd = 1'b0;
    sapi_match_first = 8'h18;
    sapi_match_second = 8'h40;
    endpoint_match_first = 8'h23;
    endpoint_match_second = 8'h45;
    smask = 8'h00;
    tmask = 8'h00;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    #1 chk({blk, eom, ovf, ovs, crce}, 8'h00);
    chk(level, 8'h00);
    rd_byte();
    chk(level, 8'h00);
    // Stuffing and flag patterns inside the data
    q = '{8'h18, 8'h23, 8'hff, 8'h7e, 8'hf8, 8'h1f};
    frame_ok(6, 1'b0);
    drain(6);
    // Address pairs, accepted and refused
    foreach (tab[k]) begin
      mk(tab[k][15:8], tab[k][7:0], 4);
      if (tab[k][16]) begin
        frame_ok(4, 1'b0);
        drain(4);
      end else begin
        frame_drop();
      end
    end
    // Masked bits of programmed values
    @(posedge mclk) smask <= 8'h04;
    tmask <= 8'h80;
    mk(8'h1c, 8'ha3, 4);
    frame_ok(4, 1'b0);
    drain(4);
    // Group values stay unmasked
    mk(8'h04, 8'hff, 4);
    frame_drop();
    mk(8'h00, 8'h7f, 4);
    frame_drop();
    // Every bit masked: any programmed pair matches
    @(posedge mclk) smask <= 8'hff;
    tmask <= 8'hff;
    mk(8'h5a, 8'h3c, 4);
    frame_ok(4, 1'b0);
    drain(4);
    // Abort after stored bytes: end with error, held tail lost
    mk(8'h18, 8'h23, 6);
    dhr_l1_model_i.send_abort(q);
    wait_end();
    chk(eom, 1'b1);
    chk(cnt, 6'h04);
    chk(crce, 1'b1);
    chk(level, 8'h04);
    drain(4);
    // Corrupted FCS
    mk(8'h18, 8'h23, 5);
    frame_ok(5, 1'b1);
    drain(5);
    // Exactly one block: end only, count zero
    mk(8'h40, 8'h45, 64);
    frame_ok(64, 1'b0);
    chk(blk, 1'b0);
    drain(64);
    // Block plus a six byte tail
    mk(8'h40, 8'h45, 70);
    frame_ok(70, 1'b0);
    chk(blk, 1'b1);
    drain(70);
    // Late host: overflow
    mk(8'h18, 8'h23, 140);
    dhr_l1_model_i.send_frame(q, 1'b0);
    repeat (20) @(posedge mclk);
    #1 chk({blk, ovf, ovs}, 8'h07);
    chk(level, 8'h80);
    drain(128);
    chk(ovs, 1'b1);
    mk(8'h18, 8'h23, 4);
    frame_ok(4, 1'b0);
    chk(ovs, 1'b0);
    drain(4);
    print_verdict();
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end
endmodule
